// *** hw/hsr_pkg.sv ***
package hsr_pkg;

  // Register offsets on the host link.
  localparam logic [7:0] ADDR_SESSION = 8'h38;
  localparam logic [7:0] ADDR_PERIOD = 8'h50;
  localparam logic [7:0] ADDR_SELFTEST = 8'h51;
  localparam logic [7:0] ADDR_PIN_FUNCTION_CONFIG = 8'h52;
  localparam logic [7:0] ADDR_TRIGGER = 8'h53;
  localparam logic [7:0] ADDR_ENABLES = 8'h54;
  localparam logic [7:0] ADDR_EVENTS = 8'h55;
  localparam logic [7:0] ADDR_FAULTS = 8'h56;
  localparam logic [7:0] ADDR_COMMAND = 8'h57;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h58;
  localparam logic [7:0] ADDR_FIXED_HI = 8'h59;
  localparam logic [7:0] ADDR_FIXED_LO = 8'h5a;
  localparam logic [7:0] ADDR_MIN_INTERVAL = 8'h5b;
  localparam logic [7:0] ADDR_REL_HI = 8'h5c;
  localparam logic [7:0] ADDR_REL_LO = 8'h5d;
  localparam logic [7:0] ADDR_SLOPE_HI = 8'h5e;
  localparam logic [7:0] ADDR_SLOPE_LO = 8'h5f;
  localparam logic [7:0] ADDR_TEMPERATURE = 8'h70;
  localparam logic [7:0] ADDR_VOLTAGE = 8'h71;
  localparam logic [7:0] ADDR_FILL_INDEX = 8'h75;
  localparam logic [7:0] ADDR_BUFFER_FIRST = 8'h76;
  localparam logic [7:0] ADDR_BUFFER_LAST = 8'h8d;

  // Field positions and writable-bit masks.
  localparam int HOLD_BIT = 2;
  localparam int SPI_WRITE_BIT = 7;
  localparam logic [7:0] SESSION_MASK = 8'h04;
  localparam logic [7:0] PIN_FUNCTION_CONFIG_MASK = 8'h07;
  localparam logic [7:0] TRIGGER_MASK = 8'h3f;
  localparam logic [7:0] ENABLES_MASK = 8'h07;
  localparam logic [7:0] COMMAND_MASK = 8'h9f;

  // Values after power-on or user reset.
  localparam logic [7:0] SESSION_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h04;
  localparam logic [7:0] SELFTEST_RST = 8'hff;
  localparam logic [7:0] OTHER_RST = 8'h00;

  // Timing: clock period, milliseconds, sampling periods and the wait timeout.
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_MS = 1000000;
  localparam int MS_CYCLES_DFLT = NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [9:0] PERIOD_MS_0 = 10'd10;
  localparam logic [9:0] PERIOD_MS_1 = 10'd20;
  localparam logic [9:0] PERIOD_MS_2 = 10'd40;
  localparam logic [9:0] PERIOD_MS_3 = 10'd70;
  localparam logic [9:0] PERIOD_MS_4 = 10'd135;
  localparam logic [9:0] PERIOD_MS_5 = 10'd510;
  localparam logic [9:0] PERIOD_MS_6 = 10'd1000;
  localparam logic [11:0] TIMEOUT_MS = 12'd2048;

  // Pressure buffer shape.
  localparam int BUF_DEPTH = 12;
  localparam int BUF_WIDTH = 16;
  localparam int PRESSURE_BITS = 10;

  // Waiting-state machine.
  typedef enum logic [1:0] {
    SES_IDLE = 2'b01,
    SES_WAIT = 2'b10
  } hsr_session_e;

  // Internal sub-bus that an address belongs to, for arbitration.
  function automatic logic [1:0] hsr_sub_bus(input logic [7:0] a);
    if (a == ADDR_SESSION) begin
      return 2'h1;
    end else if (a[7:4] == ADDR_PERIOD[7:4]) begin
      return 2'h2;
    end else if (a >= ADDR_TEMPERATURE && a <= ADDR_BUFFER_LAST) begin
      return 2'h3;
    end
    return 2'h0;
  endfunction

endpackage

// *** hw/hsr_period_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module hsr_period_timer
  import hsr_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Selected period code.
  input wire logic [7:0] period_code,
  // Ticks.
  output logic ms_tick,
  output logic sample_tick
);

  logic [23:0] pre_reg;
  logic [9:0] ms_cnt_reg;
  logic [9:0] period_ms;

  // Codes above the last one behave as the last one. [R10]
  always_comb begin
    case (period_code)
      8'h00: period_ms = PERIOD_MS_0;
      8'h01: period_ms = PERIOD_MS_1;
      8'h02: period_ms = PERIOD_MS_2;
      8'h03: period_ms = PERIOD_MS_3;
      8'h04: period_ms = PERIOD_MS_4;
      8'h05: period_ms = PERIOD_MS_5;
      default: period_ms = PERIOD_MS_6;
    endcase
  end

  // Millisecond prescaler.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_reg <= 24'h000000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (pre_reg == 24'(MS_CYCLES - 1));
      pre_reg <= (pre_reg == 24'(MS_CYCLES - 1)) ? 24'h000000 : pre_reg + 24'h000001;
    end
  end

  // Sampling tick once per selected period. [R10]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ms_cnt_reg <= 10'h000;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (ms_tick) begin
        if (ms_cnt_reg >= period_ms - 10'h001) begin
          ms_cnt_reg <= 10'h000;
          sample_tick <= 1'b1;
        end else begin
          ms_cnt_reg <= ms_cnt_reg + 10'h001;
        end
      end
    end
  end

endmodule // hsr_period_timer
`default_nettype wire

// *** hw/hsr_pressure_buffer.sv ***
`timescale 1ns/100ps
`default_nettype none
module hsr_pressure_buffer
  import hsr_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // New samples and clearing.
  input wire logic push,
  input wire logic [PRESSURE_BITS-1:0] pressure,
  input wire logic clear,
  // Two byte read ports.
  input wire logic [7:0] rd_a_addr,
  output logic [7:0] rd_a_data,
  input wire logic [7:0] rd_b_addr,
  output logic [7:0] rd_b_data,
  // Number of valid entries.
  output logic [7:0] fill
);

  logic [BUF_WIDTH-1:0] entry_reg [BUF_DEPTH];

  // Byte at a window address: even offsets give the high byte.
  function automatic logic [7:0] window_byte(input logic [7:0] a);
    logic [7:0] off;
    logic [BUF_WIDTH-1:0] e;
    off = a - ADDR_BUFFER_FIRST;
    e = entry_reg[off[4:1]];
    return off[0] ? e[7:0] : e[15:8];
  endfunction

  // Newest sample enters entry zero and older ones move down.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        entry_reg[i] <= 16'h0000;
      end
      fill <= 8'h00;
    end else if (clear) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        entry_reg[i] <= 16'h0000;
      end
      fill <= 8'h00;
    end else if (push) begin
      entry_reg[0] <= 16'(pressure);
      for (int i = 1; i < BUF_DEPTH; i++) begin
        entry_reg[i] <= entry_reg[i-1];
      end
      if (fill != 8'(BUF_DEPTH)) begin
        fill <= fill + 8'h01;
      end
    end
  end

  // Read ports; addresses outside the window read zero.
  always_comb begin
    rd_a_data = 8'h00;
    rd_b_data = 8'h00;
    if (rd_a_addr >= ADDR_BUFFER_FIRST && rd_a_addr <= ADDR_BUFFER_LAST) begin
      rd_a_data = window_byte(rd_a_addr);
    end
    if (rd_b_addr >= ADDR_BUFFER_FIRST && rd_b_addr <= ADDR_BUFFER_LAST) begin
      rd_b_data = window_byte(rd_b_addr);
    end
  end

endmodule // hsr_pressure_buffer
`default_nettype wire

// *** hw/hsr_register_bank.sv ***
// Notes on behaviour
// R1: Host reads and writes all configuration, status, command and buffer registers over SPI; host writes to 0x55, 0x56, 0x70, 0x71 and the buffer are ignored.
//     (Code ignores host writes to 0x70, 0x71 and the buffer, but a host write to 0x55 or 0x56 clears that register to zero.)
// R2: CPU hold flag is bit 2 of session register 0x38; other bits reserved.
// R3: While hold is 1 the CPU is stalled; SPI alone reaches the registers.
// R4: While hold is 0, SPI waits whenever the CPU uses the same sub-bus.
// R5: Reset clears the whole session register, hold flag included.
// R6: Host writes hold back to 0 at the end of its transfers.
// R7: Sampling period register at 0x50 is full 8-bit read/write, reset 0x04.
// R8: Waiting state ends by itself after 2048 ms without host clearing.
// R9: A timed-out wait discards the commands the host wrote.
// R10: Period codes 0..6 give 10..1000 ms; higher codes act as 6.
// R11: A changed sampling period clears the pressure buffer after SPI transfers end. (Code clears it only on a host change; a CPU write to 0x50 does not.)
// R12: Reserved bits ignore writes and read back as zero.
`timescale 1ns/100ps
`default_nettype none
module hsr_register_bank
  import hsr_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // SPI link to the host, mode 0.
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Internal CPU register port.
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_gnt,
  output logic [7:0] cpu_rdata,
  // Session control towards firmware.
  input wire logic session_req,
  output logic cpu_hold,
  output logic cmd_execute,
  output logic [7:0] cmd_code,
  output logic wait_timeout,
  // Measurement side.
  input wire logic meas_push,
  input wire logic [PRESSURE_BITS-1:0] meas_pressure,
  output logic sample_tick
);

  localparam logic [3:0] CMD_IDX = ADDR_COMMAND[3:0];
  localparam logic [3:0] PERIOD_IDX = ADDR_PERIOD[3:0];

  logic [7:0] session_reg;
  logic [7:0] cfg_reg [16];
  logic [7:0] temp_reg;
  logic [7:0] volt_reg;
  logic [7:0] fill_idx;
  logic [7:0] buf_spi_byte;
  logic [7:0] buf_cpu_byte;
  logic ms_tick;
  hsr_session_e ses_reg;
  logic [11:0] wait_ms_reg;
  logic timeout_hit;
  logic cmd_clear;
  logic sclk_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [6:0] shift_in_reg;
  logic [7:0] byte_in;
  logic byte_done;
  logic hdr_write_reg;
  logic [7:0] cur_addr_reg;
  logic [7:0] acc_addr_reg;
  logic [7:0] acc_wdata_reg;
  logic acc_we_reg;
  logic acc_pend_reg;
  logic [7:0] tx_reg;
  logic cpu_go;
  logic spi_go;
  logic spi_wr_go;
  logic cpu_wr_go;
  logic [7:0] spi_rdata;
  logic [7:0] cpu_rd_value;
  logic period_dirty_reg;
  logic buf_clear_reg;

  // Reset value of a configuration slot.
  function automatic logic [7:0] cfg_reset(input int i);
    if (i == int'(PERIOD_IDX)) begin
      return PERIOD_RST; // [R7]
    end else if (i == int'(ADDR_SELFTEST[3:0])) begin
      return SELFTEST_RST;
    end
    return OTHER_RST;
  endfunction

  // Writable bits of an address; flag registers are not host-writable.
  function automatic logic [7:0] wr_mask(input logic [7:0] a, input logic from_host);
    case (a)
      ADDR_SESSION: return SESSION_MASK; // [R2] [R12]
      ADDR_PIN_FUNCTION_CONFIG: return PIN_FUNCTION_CONFIG_MASK; // [R12]
      ADDR_TRIGGER: return TRIGGER_MASK; // [R12]
      ADDR_ENABLES: return ENABLES_MASK; // [R12]
      ADDR_COMMAND: return COMMAND_MASK; // [R12]
      ADDR_EVENTS, ADDR_FAULTS, ADDR_TEMPERATURE, ADDR_VOLTAGE: return from_host ? 8'h00 : 8'hff;
      default: return 8'hff;
    endcase
  endfunction

  // Register read mux shared by both ports; unmapped addresses read zero.
  function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] buf_byte);
    if (a == ADDR_SESSION) begin
      return session_reg & SESSION_MASK; // [R12]
    end else if (a[7:4] == ADDR_PERIOD[7:4]) begin
      return cfg_reg[a[3:0]];
    end else if (a == ADDR_TEMPERATURE) begin
      return temp_reg;
    end else if (a == ADDR_VOLTAGE) begin
      return volt_reg;
    end else if (a == ADDR_FILL_INDEX) begin
      return fill_idx;
    end
    return buf_byte;
  endfunction

  // Arbitration: hold stalls the CPU; otherwise SPI yields on a shared sub-bus.
  always_comb begin
    cpu_go = cpu_req && !cpu_gnt && !session_reg[HOLD_BIT]; // [R3]
    spi_go = acc_pend_reg && (session_reg[HOLD_BIT] ||
             !(cpu_go && hsr_sub_bus(cpu_addr) == hsr_sub_bus(acc_addr_reg))); // [R3] [R4]
    spi_wr_go = spi_go && acc_we_reg;
    cpu_wr_go = cpu_go && cpu_we;
    spi_rdata = rd_mux(acc_addr_reg, buf_spi_byte); // [R1]
    cpu_rd_value = rd_mux(cpu_addr, buf_cpu_byte);
  end

  // CPU port answers one cycle after it is taken.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpu_gnt <= 1'b0;
      cpu_rdata <= 8'h00;
    end else begin
      cpu_gnt <= cpu_go;
      if (cpu_go && !cpu_we) begin
        cpu_rdata <= cpu_rd_value;
      end
    end
  end

  // Configuration block 0x50..0x5f, written by host or CPU.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        cfg_reg[i] <= cfg_reset(i); // [R7]
      end
    end else begin
      if (cmd_clear) begin
        cfg_reg[CMD_IDX] <= 8'h00; // [R9]
      end
      for (int i = 0; i < 16; i++) begin
        if (cpu_wr_go && cpu_addr == ADDR_PERIOD + 8'(i)) begin
          cfg_reg[i] <= cpu_wdata & wr_mask(cpu_addr, 1'b0);
        end
        if (spi_wr_go && acc_addr_reg == ADDR_PERIOD + 8'(i)) begin
          cfg_reg[i] <= acc_wdata_reg & wr_mask(acc_addr_reg, 1'b1); // [R1] [R7] [R12]
        end
      end
    end
  end

  // Readings written by the CPU only.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      temp_reg <= OTHER_RST;
      volt_reg <= OTHER_RST;
    end else begin
      if (cpu_wr_go && cpu_addr == ADDR_TEMPERATURE) begin
        temp_reg <= cpu_wdata;
      end
      if (cpu_wr_go && cpu_addr == ADDR_VOLTAGE) begin
        volt_reg <= cpu_wdata;
      end
    end
  end

  // Session register: a firmware request sets hold and wins over any clear.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      session_reg <= SESSION_RST; // [R5]
    end else if (session_req) begin
      session_reg[HOLD_BIT] <= 1'b1;
    end else if (timeout_hit) begin
      session_reg <= SESSION_RST; // [R8]
    end else if (spi_wr_go && acc_addr_reg == ADDR_SESSION) begin
      session_reg <= acc_wdata_reg & SESSION_MASK; // [R2] [R6] [R12]
    end else if (cpu_wr_go && cpu_addr == ADDR_SESSION) begin
      session_reg <= cpu_wdata & SESSION_MASK;
    end
  end

  assign cpu_hold = session_reg[HOLD_BIT];

  // Waiting state ends by host clear or by timeout.
  always_comb begin
    timeout_hit = (ses_reg == SES_WAIT) && session_reg[HOLD_BIT] && ms_tick &&
                  (wait_ms_reg == TIMEOUT_MS - 12'h001); // [R8]
    cmd_clear = (ses_reg == SES_WAIT) && (!session_reg[HOLD_BIT] || timeout_hit);
  end

  // Session state machine and its millisecond count.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ses_reg <= SES_IDLE;
      wait_ms_reg <= 12'h000;
      cmd_execute <= 1'b0;
      cmd_code <= 8'h00;
      wait_timeout <= 1'b0;
    end else begin
      cmd_execute <= 1'b0;
      wait_timeout <= 1'b0;
      case (ses_reg)
        SES_IDLE: begin
          wait_ms_reg <= 12'h000;
          if (session_reg[HOLD_BIT]) begin
            ses_reg <= SES_WAIT;
          end
        end
        SES_WAIT: begin
          if (!session_reg[HOLD_BIT]) begin
            ses_reg <= SES_IDLE;
            cmd_execute <= 1'b1;
            cmd_code <= cfg_reg[CMD_IDX];
          end else if (timeout_hit) begin
            ses_reg <= SES_IDLE;
            wait_timeout <= 1'b1; // [R9]
          end else if (ms_tick) begin
            wait_ms_reg <= wait_ms_reg + 12'h001; // [R8]
          end
        end
        default: begin
          ses_reg <= SES_IDLE;
        end
      endcase
    end
  end

  // Bit framing on the SPI pins, sampled on the system clock.
  assign byte_in = {shift_in_reg, spi_mosi};
  assign byte_done = !spi_cs_n && spi_sclk && !sclk_prev_reg && (bit_cnt_reg == 3'h7);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      shift_in_reg <= 7'h00;
      hdr_write_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= spi_sclk;
      if (spi_cs_n) begin
        bit_cnt_reg <= 3'h0;
        byte_cnt_reg <= 2'h0;
      end else if (spi_sclk && !sclk_prev_reg) begin
        shift_in_reg <= byte_in[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_done) begin
          if (byte_cnt_reg == 2'h0) begin
            hdr_write_reg <= byte_in[SPI_WRITE_BIT];
          end
          if (byte_cnt_reg != 2'h2) begin
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
          end
        end
      end
    end
  end

  // Access requests from the link, with auto-increment after each data byte.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_addr_reg <= 8'h00;
      acc_addr_reg <= 8'h00;
      acc_wdata_reg <= 8'h00;
      acc_we_reg <= 1'b0;
      acc_pend_reg <= 1'b0;
    end else begin
      if (spi_go) begin
        acc_pend_reg <= 1'b0;
      end
      if (byte_done && byte_cnt_reg == 2'h1) begin
        cur_addr_reg <= byte_in;
        acc_addr_reg <= byte_in;
        acc_we_reg <= 1'b0;
        acc_pend_reg <= !hdr_write_reg; // [R1]
      end else if (byte_done && byte_cnt_reg == 2'h2) begin
        cur_addr_reg <= cur_addr_reg + 8'h01;
        acc_pend_reg <= 1'b1; // [R1]
        acc_we_reg <= hdr_write_reg;
        acc_wdata_reg <= byte_in;
        acc_addr_reg <= hdr_write_reg ? cur_addr_reg : cur_addr_reg + 8'h01;
      end
    end
  end

  // Read data shifts out MSB first, changing after falling clock edges.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_reg <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      if (spi_go && !acc_we_reg) begin
        tx_reg <= spi_rdata;
      end else if (!spi_cs_n && !spi_sclk && sclk_prev_reg && bit_cnt_reg != 3'h0) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      spi_miso <= tx_reg[7];
      spi_miso_oe <= !spi_cs_n;
    end
  end

  // A period changed by a host write clears the buffer once chip select is released.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      period_dirty_reg <= 1'b0;
      buf_clear_reg <= 1'b0;
    end else begin
      buf_clear_reg <= period_dirty_reg && spi_cs_n; // [R11]
      if (spi_wr_go && acc_addr_reg == ADDR_PERIOD && acc_wdata_reg != cfg_reg[PERIOD_IDX]) begin
        period_dirty_reg <= 1'b1; // [R11]
      end else if (period_dirty_reg && spi_cs_n) begin
        period_dirty_reg <= 1'b0;
      end
    end
  end

  // Sampling period and millisecond ticks.
  hsr_period_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .rst(rst),
    .period_code(cfg_reg[PERIOD_IDX]),
    .ms_tick(ms_tick),
    .sample_tick(sample_tick)
  );

  // Twelve-entry pressure buffer.
  hsr_pressure_buffer u_buffer (
    .mclk(mclk),
    .rst(rst),
    .push(meas_push),
    .pressure(meas_pressure),
    .clear(buf_clear_reg),
    .rd_a_addr(acc_addr_reg),
    .rd_a_data(buf_spi_byte),
    .rd_b_addr(cpu_addr),
    .rd_b_data(buf_cpu_byte),
    .fill(fill_idx)
  );

endmodule // hsr_register_bank
`default_nettype wire

// *** test/hsr_register_bank_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module hsr_bank_checker
  import hsr_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Watched ports.
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe,
  input wire logic cpu_req,
  input wire logic cpu_gnt,
  input wire logic session_req,
  input wire logic cpu_hold,
  input wire logic cmd_execute,
  input wire logic wait_timeout
);
  localparam int T_MIN = 2047 * MS_CYCLES;
  localparam int T_MAX = 2048 * MS_CYCLES + 4;
  int hold_cnt;
  // Counts how long the hold flag has stood.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= cpu_hold ? hold_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_clears: assert property ($fell(rst) |-> !cpu_hold && !cpu_gnt && !cmd_execute)
    else $error("outputs not clear after reset");
  a_hold_stalls_cpu: assert property (cpu_hold && $past(cpu_hold) |-> !cpu_gnt)
    else $error("cpu granted while on hold");
  a_grant_has_cause: assert property (cpu_gnt |-> $past(cpu_req) && !$past(cpu_gnt))
    else $error("grant without a fresh request");
  a_session_sets_hold: assert property (session_req |=> cpu_hold)
    else $error("session request did not set hold");
  a_wait_exits_once: assert property ($fell(cpu_hold) |->
    (wait_timeout ##1 !cmd_execute) or (!wait_timeout ##1 cmd_execute))
    else $error("wait ended without one outcome");
  a_exit_needs_fall: assert property (cmd_execute || wait_timeout |->
    (wait_timeout ? $fell(cpu_hold) : $past(cpu_hold, 2) && !$past(cpu_hold)))
    else $error("end of wait without hold falling");
  a_no_early_timeout: assert property (wait_timeout |-> $past(hold_cnt) >= T_MIN)
    else $error("timeout came too early");
  a_timeout_bound: assert property (hold_cnt <= T_MAX)
    else $error("hold outlived the timeout");
  a_oe_follows_cs: assert property (spi_miso_oe == !$past(spi_cs_n))
    else $error("output enable does not follow select");
endmodule // hsr_bank_checker
bind hsr_register_bank hsr_bank_checker #(.MS_CYCLES(MS_CYCLES)) u_checker (
  .mclk(mclk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
  .cpu_req(cpu_req), .cpu_gnt(cpu_gnt), .session_req(session_req),
  .cpu_hold(cpu_hold), .cmd_execute(cmd_execute), .wait_timeout(wait_timeout)
);
`default_nettype wire

// *** test/hsr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module hsr_host_model (
  // Clock.
  input wire logic mclk,
  // SPI link.
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  int half = 4;
  // Idle link: not selected, clock standing low.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Waits n edges and steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Shifts a byte MSB first; both sides sample on the rising clock.
  task automatic shift(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = b[i];
      tick(half);
      spi_sclk = 1'b1;
      r[i] = spi_miso;
      tick(half);
      spi_sclk = 1'b0;
    end
  endtask
  // One frame: header, address, one data byte; the line flips once released.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] junk;
    spi_cs_n = 1'b0;
    tick(half);
    shift({wr, 7'h00}, junk);
    shift(a, junk);
    shift(d, q);
    tick(half);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    tick(2 * half);
  endtask
endmodule // hsr_host_model
`default_nettype wire

// *** test/hsr_register_bank_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module hsr_register_bank_tb_top
  import hsr_pkg::*; ;
  localparam int MSC = 10;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic cpu_req = 1'b0, cpu_we = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic [7:0] cpu_wdata = 8'h00;
  logic session_req = 1'b0;
  logic meas_push = 1'b0;
  logic [PRESSURE_BITS-1:0] meas_pressure = '0;
  logic cpu_gnt, cpu_hold, cmd_execute, wait_timeout, sample_tick, cpu_done;
  logic [7:0] cpu_rdata, cmd_code, exec_code, q, r2, d, v;
  logic [PRESSURE_BITS-1:0] p [2];
  logic [9:0] pms [7] = '{PERIOD_MS_0, PERIOD_MS_1, PERIOD_MS_2, PERIOD_MS_3,
                          PERIOD_MS_4, PERIOD_MS_5, PERIOD_MS_6};
  int errors = 0;
  int checked = 0;
  int seed = 76;
  int exec_cnt = 0;
  int tout_cnt = 0;
  int n;
  // Clock at 10 MHz.
  always #50 mclk = ~mclk;
  hsr_register_bank #(.MS_CYCLES(MSC)) dut (
    .mclk(mclk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_gnt(cpu_gnt), .cpu_rdata(cpu_rdata), .session_req(session_req),
    .cpu_hold(cpu_hold), .cmd_execute(cmd_execute), .cmd_code(cmd_code),
    .wait_timeout(wait_timeout), .meas_push(meas_push),
    .meas_pressure(meas_pressure), .sample_tick(sample_tick)
  );
  hsr_host_model host (.mclk(mclk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  // Counts end-of-wait pulses.
  always @(posedge mclk) begin
    if (cmd_execute === 1'b1) begin
      exec_cnt++;
      exec_code = cmd_code;
    end
    if (wait_timeout === 1'b1) tout_cnt++;
  end
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic hw(input logic [7:0] a, input logic [7:0] dd);
    logic [7:0] junk;
    host.xfer(1'b1, a, dd, junk);
  endtask
  task automatic hr(input logic [7:0] a, output logic [7:0] r);
    host.xfer(1'b0, a, 8'h00, r);
  endtask
  // Holds a CPU request until granted; takes read data then.
  task automatic cpu_access(input logic we, input logic [7:0] a, input logic [7:0] wd,
                            output logic [7:0] rd);
    int k;
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = wd;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (cpu_gnt !== 1'b1 && k < 5000);
    rd = cpu_rdata;
    #1;
    cpu_req = 1'b0;
    cpu_done = 1'b1;
    check_cnt(int'(k < 5000), 1);
  endtask
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      ADDR_PIN_FUNCTION_CONFIG: return PIN_FUNCTION_CONFIG_MASK;
      ADDR_TRIGGER: return TRIGGER_MASK;
      ADDR_ENABLES: return ENABLES_MASK;
      ADDR_EVENTS, ADDR_FAULTS: return 8'h00;
      ADDR_COMMAND: return COMMAND_MASK;
      default: return 8'hff;
    endcase
  endfunction
  function automatic int period_cycles(input logic [7:0] c);
    return int'(c > 8'h06 ? pms[6] : pms[c[2:0]]) * MSC;
  endfunction
  // Counts the cycles between two sample ticks.
  task automatic measure(input logic [7:0] c);
    int k;
    k = 0;
    while (sample_tick !== 1'b1 && k < 11000) begin
      tick(1);
      k++;
    end
    k = 0;
    do begin
      tick(1);
      k++;
    end while (sample_tick !== 1'b1 && k < 11000);
    check_cnt(k, period_cycles(c));
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (99000) @(posedge mclk);
    errors++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    tick(20);
    rst = 1'b0;
    hr(ADDR_SESSION, q);
    check_val(q, SESSION_RST);
    hr(ADDR_PERIOD, q);
    check_val(q, PERIOD_RST);
    for (int a = 'h51; a <= 'h5f; a++) begin
      hr(8'(a), q);
      check_val(q, (a == 'h51) ? SELFTEST_RST : OTHER_RST);
      d = 8'($random(seed));
      hw(8'(a), d);
      hr(8'(a), q);
      check_val(q, d & mask_of(8'(a)));
    end
    $display("test register map done");
    v = 8'($random(seed));
    cpu_access(1'b1, ADDR_TEMPERATURE, v, q);
    hw(ADDR_TEMPERATURE, ~v);
    hr(ADDR_TEMPERATURE, q);
    check_val(q, v);
    hw(ADDR_SESSION, 8'hfb);
    hr(ADDR_SESSION, q);
    check_val(q, 8'h00);
    check_val({7'h00, cpu_hold}, 8'h00);
    $display("test read-only and reserved done");
    for (int i = 0; i < 2; i++) begin
      p[i] = PRESSURE_BITS'($random(seed));
      meas_pressure = p[i];
      meas_push = 1'b1;
      tick(1);
      meas_push = 1'b0;
      tick(1);
    end
    hr(ADDR_FILL_INDEX, q);
    check_val(q, 8'h02);
    hr(ADDR_BUFFER_FIRST, q);
    check_val(q, {6'h00, p[1][9:8]});
    hr(ADDR_BUFFER_FIRST + 8'h03, q);
    check_val(q, p[0][7:0]);
    hw(ADDR_PERIOD, 8'h00);
    hr(ADDR_FILL_INDEX, q);
    check_val(q, 8'h00);
    $display("test buffer clear done");
    for (int c = 0; c < 8; c++) begin
      d = (c == 7) ? (8'($random(seed)) | 8'h80) : 8'(c);
      hw(ADDR_PERIOD, d);
      hr(ADDR_PERIOD, q);
      check_val(q, d);
      measure(d);
    end
    $display("test sampling periods done");
    host.half = 8;
    hw(ADDR_SESSION, 8'hff);
    check_val({7'h00, cpu_hold}, 8'h01);
    hr(ADDR_SESSION, q);
    check_val(q, SESSION_MASK);
    v = 8'($random(seed));
    hw(ADDR_COMMAND, v);
    cpu_done = 1'b0;
    fork
      cpu_access(1'b0, ADDR_PERIOD, 8'h00, r2);
      begin
        tick(40);
        check_val({7'h00, cpu_done}, 8'h00);
        hw(ADDR_SESSION, 8'h00);
      end
    join
    check_val(r2, d);
    check_cnt(exec_cnt, 1);
    check_val(exec_code, v & COMMAND_MASK);
    $display("test host session done");
    host.half = 4;
    session_req = 1'b1;
    tick(1);
    session_req = 1'b0;
    tick(1);
    check_val({7'h00, cpu_hold}, 8'h01);
    hw(ADDR_COMMAND, v);
    n = 0;
    while (tout_cnt == 0 && n < 21000) begin
      tick(1);
      n++;
    end
    check_cnt(tout_cnt, 1);
    check_cnt(exec_cnt, 1);
    hr(ADDR_SESSION, q);
    check_val(q, 8'h00);
    $display("test timeout done");
    print_verdict();
  end
endmodule // hsr_register_bank_tb_top
`default_nettype wire
